/* logic/spio_pkg.sv */
// Constants and types shared by the parallel I/O port logic
package spio_pkg;

  localparam int PIN_COUNT    = 26;
  localparam int PORT_COUNT   = 4;
  localparam int PORT_W       = 8;
  localparam int ANALOG_REGS  = 2;
  localparam int ANALOG_COUNT = 16;
  localparam int ADDR_W       = 8;
  localparam int DATA_W       = 32;
  localparam int BE_W         = 4;

  // Ports in order 8, 9, A, B inside the packed pin vector
  localparam int   PORT_WIDTH [PORT_COUNT]      = '{8, 2, 8, 8};
  localparam int   PORT_LSB [PORT_COUNT]        = '{0, 8, 10, 18};
  localparam bit   PORT_OPEN_DRAIN [PORT_COUNT] = '{1'b0, 1'b1, 1'b0, 1'b0};
  localparam logic [PORT_W-1:0] PORT_MASK [PORT_COUNT] = '{8'hff, 8'h03, 8'hff, 8'hff};
  localparam int   ANALOG_PORT_FIRST = 2;

  // Register byte offsets, one 32-bit word each
  localparam logic [ADDR_W-1:0] OFS_VALUE_BASE  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_DIR_BASE    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_ANALOG_BASE = 8'h20;
  localparam int                REG_STRIDE      = 4;
  localparam int                LANE0           = 0;

  // Reset values
  localparam logic [PORT_W-1:0]    VALUE_RST     = 8'h00;
  localparam logic [PORT_W-1:0]    DIR_RST       = 8'h00;
  localparam logic [PORT_W-1:0]    ANALOG_RST    = 8'hff;
  localparam logic [PIN_COUNT-1:0] PINS_RELEASED = 26'h3ffffff;
  localparam logic [PIN_COUNT-1:0] PINS_LOW      = 26'h0000000;
  localparam logic [DATA_W-1:0]    DATA_ZERO     = 32'h00000000;

  // Pin positions of the shared peripheral functions
  localparam int PIN_IRQ0_CAP0       = 0;
  localparam int PIN_IRQ1_CAP1       = 1;
  localparam int PIN_UART0_RX        = 2;
  localparam int PIN_UART0_CLK       = 3;
  localparam int PIN_UART0_TX        = 4;
  localparam int PIN_UART1_RX        = 5;
  localparam int PIN_UART1_CLK       = 6;
  localparam int PIN_UART1_TX        = 7;
  localparam int PIN_SDA_SER3_OUT    = 8;
  localparam int PIN_SCL_SER3_CLK    = 9;
  localparam int PIN_TIME_CLOCK      = 10;
  localparam int PIN_SER2_IN         = 21;
  localparam int PIN_SER2_CLK_TMR_IN = 22;
  localparam int PIN_SER2_OUT_TMR_OUT = 23;
  localparam int PIN_IRQ2            = 24;
  localparam int PIN_IRQ3            = 25;

  // Pin drive bundle: level and active-low output enable
  typedef struct packed {
    logic [PIN_COUNT-1:0] level;
    logic [PIN_COUNT-1:0] oe_n;
  } spio_pin_drive_t;

  // Pin levels handed to the peripheral functions
  typedef struct packed {
    logic [3:0] ext_irq_in;
    logic [1:0] capture_in;
    logic [1:0] uart_rx;
    logic [1:0] uart_clk_in;
    logic       i2c_sda_in;
    logic       i2c_scl_in;
    logic       serial3_clk_in;
    logic       serial2_in;
    logic       serial2_clk_in;
    logic       timer0_in;
  } spio_periph_in_t;

  // Drive requests from the peripheral functions
  typedef struct packed {
    logic [1:0] uart_tx;
    logic [1:0] uart_tx_en;
    logic [1:0] uart_clk;
    logic [1:0] uart_clk_en;
    logic       i2c_sda;
    logic       i2c_sda_en;
    logic       i2c_scl;
    logic       i2c_scl_en;
    logic       serial3_out;
    logic       serial3_out_en;
    logic       serial3_shift_clock;
    logic       serial3_clk_en;
    logic       time_clock_output;
    logic       time_clock_en;
    logic       serial2_out;
    logic       serial2_out_en;
    logic       serial2_clk;
    logic       serial2_clk_en;
    logic       timer0_out;
    logic       timer0_out_en;
  } spio_periph_out_t;

endpackage : spio_pkg

/* logic/spio_port_slice.sv */
// Per-port pin drive, input gating and read-back logic
`timescale 1ns/1ps
module spio_port_slice
  import spio_pkg::*;
#(
  parameter int WIDTH      = PORT_W,
  parameter bit OPEN_DRAIN = 1'b0
) (
  input  wire logic [WIDTH-1:0] value_i,
  input  wire logic [WIDTH-1:0] dir_i,
  input  wire logic [WIDTH-1:0] analog_i,
  input  wire logic [WIDTH-1:0] pin_in_i,
  input  wire logic [WIDTH-1:0] alt_en_i,
  input  wire logic [WIDTH-1:0] alt_val_i,
  output logic      [WIDTH-1:0] level_o,
  output logic      [WIDTH-1:0] oe_n_o,
  output logic      [WIDTH-1:0] digital_in_o,
  output logic      [WIDTH-1:0] read_o
);

  // Bitwise drive choice, analog gating and read-back selection
  always_comb begin
    logic drive;
    logic lvl;
    logic dig;
    drive = 1'b0;
    lvl   = 1'b0;
    dig   = 1'b0;
    for (int b = 0; b < WIDTH; b++) begin
      drive = alt_en_i[b] | dir_i[b];
      lvl   = alt_en_i[b] ? alt_val_i[b] : value_i[b];
      dig   = pin_in_i[b] & ~analog_i[b];
      digital_in_o[b] = dig;
      read_o[b] = dir_i[b] ? value_i[b] : dig;
      if (OPEN_DRAIN) begin
        level_o[b] = 1'b0;                            // Only pulls low
        oe_n_o[b]  = ~(drive & ~lvl);
      end else begin
        level_o[b] = lvl;
        oe_n_o[b]  = ~drive;
      end
    end
  end

endmodule : spio_port_slice

/* logic/spio_ports.sv */
// Top of the shared parallel I/O ports with an Avalon-MM register slave
//
// Local design decisions: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
// Function
// - Up to 26 pins over four ports, each also usable by a peripheral.
// - Each pin has its own direction bit choosing input or output.
// - Writing a port value register stores data driven on output pins.
// - Reading a digital input pin returns the live pin level, not stored data.
// - An output pin is driven with its bit of the value register unless an enabled peripheral drives it; port 9 pins only pull low.
// - Reset sets both analog enable registers to all ones.
// - First eight-pin port shares external interrupts, capture and two serial channels.
// - Two-pin port shares I2C data/clock and serial channel 3 output/clock.
// - Third port doubles as analog inputs; one pin carries the time clock.
// - Fourth port carries analog, serial 2, two interrupts, timer 0 lines.
module spio_ports
  import spio_pkg::*;
(
  input  wire logic                    sys_clk_i,
  input  wire logic                    reset_i,
  input  wire logic [ADDR_W-1:0]       avs_address_i,
  input  wire logic                    avs_read_i,
  input  wire logic                    avs_write_i,
  input  wire logic [DATA_W-1:0]       avs_writedata_i,
  input  wire logic [BE_W-1:0]         avs_byteenable_i,
  output logic      [DATA_W-1:0]       avs_readdata_o,
  output logic                         avs_waitrequest_o,
  input  wire logic [PIN_COUNT-1:0]    pin_in_i,
  output spio_pin_drive_t              pins_o,
  input  wire spio_periph_out_t        periph_out_i,
  output spio_periph_in_t              periph_in_o,
  output logic      [ANALOG_COUNT-1:0] analog_sel_o
);

  // Match an address against the word of register idx above base
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] base,
                                   input int                idx);
    reg_hit = (addr == ADDR_W'(int'(base) + REG_STRIDE * idx));
  endfunction : reg_hit

  // Register map, one byte of state in each 32-bit word:
  //   0x00  value of port 8
  //   0x04  value of port 9
  //   0x08  value of port A
  //   0x0c  value of port B
  //   0x10  direction of port 8, bit set = output
  //   0x14  direction of port 9, bit set = output
  //   0x18  direction of port A, bit set = output
  //   0x1c  direction of port B, bit set = output
  //   0x20  analog enables of port A, bit set = analog
  //   0x24  analog enables of port B, bit set = analog
  //   Bits 31:8 read zero; port 9 keeps only bits 1:0
  //   Writes take effect only with byte lane 0 enabled
  //   Unmapped words read zero and ignore writes
  //   Every access takes two cycles: one wait, then the answer
  //   Reset: values zero, all pins input, all analog enables set
  //   Analog pins set as input read zero until their enable is cleared; output pins read their value bit
  // Register file state
  logic [PORT_W-1:0] pin_value_reg [PORT_COUNT];
  logic [PORT_W-1:0] pin_value_next [PORT_COUNT];
  logic [PORT_W-1:0] direction_reg [PORT_COUNT];
  logic [PORT_W-1:0] direction_next [PORT_COUNT];
  logic [PORT_W-1:0] analog_input_enable_reg [ANALOG_REGS];
  logic [PORT_W-1:0] analog_input_enable_next [ANALOG_REGS];

  // Bus handshake state
  logic              ack_reg;
  logic              ack_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic              req;
  logic              wr_commit;
  logic [PORT_W-1:0] wr_byte;
  logic [DATA_W-1:0] rd_word;

  // Pin side state
  spio_pin_drive_t   pins_reg;
  spio_pin_drive_t   pins_next;
  spio_periph_in_t   periph_in_reg;
  spio_periph_in_t   periph_in_next;

  // Combinational pin vectors
  logic [PIN_COUNT-1:0] alt_en;
  logic [PIN_COUNT-1:0] alt_val;
  logic [PIN_COUNT-1:0] drive_level;
  logic [PIN_COUNT-1:0] drive_oe_n;
  logic [PIN_COUNT-1:0] dig_in;
  logic [PORT_W-1:0]    port_read [PORT_COUNT];
  logic [PORT_W-1:0]    port_analog [PORT_COUNT];

  // Two-cycle bus access: wait one cycle, then answer
  assign req               = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_reg;
  assign wr_commit         = avs_write_i & ack_reg & avs_byteenable_i[LANE0];
  assign wr_byte           = avs_writedata_i[PORT_W-1:0];
  assign avs_readdata_o    = rdata_reg;

  // Read multiplexer over the mapped words; others read zero
  always_comb begin
    rd_word = DATA_ZERO;
    for (int i = 0; i < PORT_COUNT; i++) begin
      if (reg_hit(avs_address_i, OFS_VALUE_BASE, i)) begin
        rd_word = DATA_W'(port_read[i]);
      end else if (reg_hit(avs_address_i, OFS_DIR_BASE, i)) begin
        rd_word = DATA_W'(direction_reg[i]);
      end
    end
    for (int j = 0; j < ANALOG_REGS; j++) begin
      if (reg_hit(avs_address_i, OFS_ANALOG_BASE, j)) begin
        rd_word = DATA_W'(analog_input_enable_reg[j]);
      end
    end
  end

  // Next state of the bus handshake
  always_comb begin
    ack_next   = req & ~ack_reg;
    rdata_next = rdata_reg;
    if (avs_read_i && !ack_reg) begin
      rdata_next = rd_word;
    end
  end

  // Bus handshake registers
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ack_reg   <= 1'b0;
      rdata_reg <= DATA_ZERO;
    end else begin
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  // Register writes, masked to each port's width
  always_comb begin
    pin_value_next           = pin_value_reg;
    direction_next           = direction_reg;
    analog_input_enable_next = analog_input_enable_reg;
    for (int i = 0; i < PORT_COUNT; i++) begin
      if (wr_commit && reg_hit(avs_address_i, OFS_VALUE_BASE, i)) begin
        pin_value_next[i] = wr_byte & PORT_MASK[i];
      end else if (wr_commit && reg_hit(avs_address_i, OFS_DIR_BASE, i)) begin
        direction_next[i] = wr_byte & PORT_MASK[i];
      end
    end
    for (int j = 0; j < ANALOG_REGS; j++) begin
      if (wr_commit && reg_hit(avs_address_i, OFS_ANALOG_BASE, j)) begin
        analog_input_enable_next[j] = wr_byte;
      end
    end
  end

  // Register file flip-flops
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < PORT_COUNT; i++) begin
        pin_value_reg[i] <= VALUE_RST;
        direction_reg[i] <= DIR_RST;
      end
      for (int j = 0; j < ANALOG_REGS; j++) begin
        analog_input_enable_reg[j] <= ANALOG_RST;
      end
    end else begin
      pin_value_reg           <= pin_value_next;
      direction_reg           <= direction_next;
      analog_input_enable_reg <= analog_input_enable_next;
    end
  end

  // Analog enables apply only to ports A and B
  always_comb begin
    for (int i = 0; i < PORT_COUNT; i++) begin
      port_analog[i] = '0;                                 // Ports 8 and 9 stay digital
    end
    for (int j = 0; j < ANALOG_REGS; j++) begin
      port_analog[ANALOG_PORT_FIRST + j] = analog_input_enable_reg[j];
    end
  end

  // Pin map of the packed pin vector and its shared functions:
  //   0  port 8 bit 0: external interrupt 0, capture 0
  //   1  port 8 bit 1: external interrupt 1, capture 1
  //   2  port 8 bit 2: serial 0 receive
  //   3  port 8 bit 3: serial 0 clock
  //   4  port 8 bit 4: serial 0 transmit
  //   5  port 8 bit 5: serial 1 receive
  //   6  port 8 bit 6: serial 1 clock
  //   7  port 8 bit 7: serial 1 transmit
  //   8  port 9 bit 0: I2C data, serial 3 output, open drain
  //   9  port 9 bit 1: I2C clock, serial 3 clock, open drain
  //   10 port A bit 0: analog input 0, time clock output
  //   11 port A bit 1: analog input 1
  //   12 port A bit 2: analog input 2
  //   13 port A bit 3: analog input 3
  //   14 port A bit 4: analog input 4
  //   15 port A bit 5: analog input 5
  //   16 port A bit 6: analog input 6
  //   17 port A bit 7: analog input 7
  //   18 port B bit 0: analog input 8
  //   19 port B bit 1: analog input 9
  //   20 port B bit 2: analog input 10
  //   21 port B bit 3: analog input 11, serial 2 input
  //   22 port B bit 4: analog input 12, serial 2 clock, timer 0 input
  //   23 port B bit 5: analog input 13, serial 2 output, timer 0 output
  //   24 port B bit 6: analog input 14, external interrupt 2
  //   25 port B bit 7: analog input 15, external interrupt 3
  //   Hazard: an enabled peripheral drives its pin whatever the direction bit says
  // Peripheral drive requests routed onto their shared pins
  always_comb begin
    alt_en  = '0;
    alt_val = '0;
    // Port 8: both asynchronous serial channels
    alt_en[PIN_UART0_CLK]  = periph_out_i.uart_clk_en[0];
    alt_val[PIN_UART0_CLK] = periph_out_i.uart_clk[0];
    alt_en[PIN_UART0_TX]   = periph_out_i.uart_tx_en[0];
    alt_val[PIN_UART0_TX]  = periph_out_i.uart_tx[0];
    alt_en[PIN_UART1_CLK]  = periph_out_i.uart_clk_en[1];
    alt_val[PIN_UART1_CLK] = periph_out_i.uart_clk[1];
    alt_en[PIN_UART1_TX]   = periph_out_i.uart_tx_en[1];
    alt_val[PIN_UART1_TX]  = periph_out_i.uart_tx[1];
    // Port 9: I2C wins over serial channel 3 on each pin
    alt_en[PIN_SDA_SER3_OUT]  = periph_out_i.i2c_sda_en | periph_out_i.serial3_out_en;
    alt_val[PIN_SDA_SER3_OUT] = periph_out_i.i2c_sda_en ? periph_out_i.i2c_sda
                                                        : periph_out_i.serial3_out;
    alt_en[PIN_SCL_SER3_CLK]  = periph_out_i.i2c_scl_en | periph_out_i.serial3_clk_en;
    alt_val[PIN_SCL_SER3_CLK] = periph_out_i.i2c_scl_en ? periph_out_i.i2c_scl
                                                        : periph_out_i.serial3_shift_clock;
    // Port A: time clock output
    alt_en[PIN_TIME_CLOCK]  = periph_out_i.time_clock_en;
    alt_val[PIN_TIME_CLOCK] = periph_out_i.time_clock_output;
    // Port B: serial channel 2 wins over reload timer 0 output
    alt_en[PIN_SER2_CLK_TMR_IN]  = periph_out_i.serial2_clk_en;
    alt_val[PIN_SER2_CLK_TMR_IN] = periph_out_i.serial2_clk;
    alt_en[PIN_SER2_OUT_TMR_OUT] = periph_out_i.serial2_out_en | periph_out_i.timer0_out_en;
    alt_val[PIN_SER2_OUT_TMR_OUT] = periph_out_i.serial2_out_en ? periph_out_i.serial2_out
                                                                : periph_out_i.timer0_out;
  end

  // One slice per port; port 9 is open drain
  for (genvar g = 0; g < PORT_COUNT; g++) begin : g_port
    localparam int W = PORT_WIDTH[g];
    localparam int L = PORT_LSB[g];
    logic [W-1:0] s_read;

    spio_port_slice #(
      .WIDTH      (W),
      .OPEN_DRAIN (PORT_OPEN_DRAIN[g])
    ) u_slice (
      .value_i      (pin_value_reg[g][W-1:0]),
      .dir_i        (direction_reg[g][W-1:0]),
      .analog_i     (port_analog[g][W-1:0]),
      .pin_in_i     (pin_in_i[L +: W]),
      .alt_en_i     (alt_en[L +: W]),
      .alt_val_i    (alt_val[L +: W]),
      .level_o      (drive_level[L +: W]),
      .oe_n_o       (drive_oe_n[L +: W]),
      .digital_in_o (dig_in[L +: W]),
      .read_o       (s_read)
    );

    // Widen the port read-back to a byte
    assign port_read[g] = PORT_W'(s_read);
  end

  // Pin levels gathered for the peripheral inputs
  always_comb begin
    pins_next.level = drive_level;
    pins_next.oe_n  = drive_oe_n;
    periph_in_next.ext_irq_in  = {dig_in[PIN_IRQ3], dig_in[PIN_IRQ2],
                                  dig_in[PIN_IRQ1_CAP1], dig_in[PIN_IRQ0_CAP0]};
    periph_in_next.capture_in  = {dig_in[PIN_IRQ1_CAP1], dig_in[PIN_IRQ0_CAP0]};
    periph_in_next.uart_rx     = {dig_in[PIN_UART1_RX], dig_in[PIN_UART0_RX]};
    periph_in_next.uart_clk_in = {dig_in[PIN_UART1_CLK], dig_in[PIN_UART0_CLK]};
    periph_in_next.i2c_sda_in     = dig_in[PIN_SDA_SER3_OUT];
    periph_in_next.i2c_scl_in     = dig_in[PIN_SCL_SER3_CLK];
    periph_in_next.serial3_clk_in = dig_in[PIN_SCL_SER3_CLK];
    periph_in_next.serial2_in     = dig_in[PIN_SER2_IN];
    periph_in_next.serial2_clk_in = dig_in[PIN_SER2_CLK_TMR_IN];
    periph_in_next.timer0_in      = dig_in[PIN_SER2_CLK_TMR_IN];
  end

  // Pin and peripheral outputs come from flip-flops
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pins_reg.level <= PINS_LOW;
      pins_reg.oe_n  <= PINS_RELEASED;
      periph_in_reg  <= '0;
    end else begin
      pins_reg       <= pins_next;
      periph_in_reg  <= periph_in_next;
    end
  end

  // Output assignments
  assign pins_o       = pins_reg;
  assign periph_in_o  = periph_in_reg;
  assign analog_sel_o = {analog_input_enable_reg[1], analog_input_enable_reg[0]};

endmodule : spio_ports

/* sim/spio_ports_checker.sv */
// Concurrent checks on the parallel I/O port top
`timescale 1ns/1ps
module spio_ports_checker
  import spio_pkg::*;
(
  input wire logic             sys_clk_i,
  input wire logic             reset_i,
  input wire logic [7:0]       avs_address_i,
  input wire logic             avs_read_i,
  input wire logic             avs_write_i,
  input wire logic [31:0]      avs_writedata_i,
  input wire logic [3:0]       avs_byteenable_i,
  input wire logic [31:0]      avs_readdata_o,
  input wire logic             avs_waitrequest_o,
  input wire logic [25:0]      pin_in_i,
  input wire spio_pin_drive_t  pins_o,
  input wire spio_periph_out_t periph_out_i,
  input wire spio_periph_in_t  periph_in_o,
  input wire logic [15:0]      analog_sel_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // First cycle of a read, when live pins are sampled
  logic rd_first;
  assign rd_first = avs_read_i & avs_waitrequest_o;

  wait_once_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("access not answered after one wait");
  rst_analog_a: assert property (disable iff (1'b0) reset_i |=> analog_sel_o == 16'hffff)
    else $error("analog enables not set by reset");
  rst_release_a: assert property (disable iff (1'b0) reset_i |=> pins_o.oe_n == PINS_RELEASED)
    else $error("pin driven during reset");
  in_read_a: assert property (rd_first && avs_address_i == 8'h00 && pins_o.oe_n[7:0] == 8'hff
    |=> avs_readdata_o[7:0] == $past(pin_in_i[7:0])) else $error("input read not live level");
  out_read_a: assert property (rd_first && avs_address_i == 8'h00 && pins_o.oe_n[7:0] == 8'h00
    && periph_out_i.uart_tx_en == 2'b00 && periph_out_i.uart_clk_en == 2'b00
    |=> avs_readdata_o[7:0] == pins_o.level[7:0]) else $error("output read differs from pins");
  ana_read_a: assert property (rd_first && avs_address_i == 8'h08 && analog_sel_o[7:0] == 8'hff
    && pins_o.oe_n[17:10] == 8'hff |=> avs_readdata_o[7:0] == 8'h00) else $error("analog pin read");
  od_level_a: assert property (pins_o.level[9:8] == 2'b00) else $error("open drain drives high");
  sda_pull_a: assert property (!$past(reset_i) && $past(periph_out_i.i2c_sda_en)
    |-> pins_o.oe_n[8] == $past(periph_out_i.i2c_sda)) else $error("data line drive wrong");
  tclk_out_a: assert property (!$past(reset_i) && $past(periph_out_i.time_clock_en)
    |-> !pins_o.oe_n[10] && pins_o.level[10] == $past(periph_out_i.time_clock_output))
    else $error("time clock not on pin");
  irq0_in_a: assert property (!$past(reset_i)
    |-> periph_in_o.ext_irq_in[0] == $past(pin_in_i[0])) else $error("irq0 input path");
  ser2_cut_a: assert property (analog_sel_o[11] && $past(analog_sel_o[11])
    |-> !periph_in_o.serial2_in) else $error("analog pin reaches serial 2");
  // Main scenarios
  cov_in_read: cover property (rd_first && avs_address_i == 8'h00 && pins_o.oe_n[7:0] == 8'hff);
  cov_tclk: cover property (periph_out_i.time_clock_en);
  cov_sda: cover property (periph_out_i.i2c_sda_en && !periph_out_i.i2c_sda);
endmodule : spio_ports_checker

bind spio_ports spio_ports_checker u_chk (.*);

/* sim/spio_pin_model.sv */
// Pin wiring model: resolves drive, pull-ups and external levels
`timescale 1ns/1ps
module spio_pin_model
  import spio_pkg::*;
(
  input  wire spio_pin_drive_t     drive_i,
  input  wire logic [PIN_COUNT-1:0] ext_i,
  output logic      [PIN_COUNT-1:0] pin_o
);
  // Driven pins show the drive, the open-drain pair floats to the pull-up
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (!drive_i.oe_n[i]) pin_o[i] = drive_i.level[i];
      else if (i == 8 || i == 9) pin_o[i] = 1'b1;
      else pin_o[i] = ext_i[i];
    end
  end
endmodule : spio_pin_model

/* sim/spio_ports_tb_top.sv */
// Self-checking bench for the shared parallel I/O ports
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
  $display("mismatch at %0t: got %h want %h", $time, (a), (b)); end end
module spio_ports_tb_top
  import spio_pkg::*;
();
  logic             sys_clk_i = 1'b0;
  logic             reset_i   = 1'b1;
  logic [7:0]       adr       = 8'h00;
  logic             rd        = 1'b0;
  logic             wr        = 1'b0;
  logic [31:0]      wdat      = 32'h0;
  logic [3:0]       ben       = 4'h0;
  logic [31:0]      rdat;
  logic [31:0]      q;
  logic             wreq;
  logic [25:0]      pin_in;
  logic [25:0]      ext       = 26'h0;
  spio_pin_drive_t  pins;
  spio_periph_out_t pout      = '0;
  spio_periph_in_t  pin_f;
  logic [15:0]      asel;
  int               num_errors = 0;
  int               cmp_count  = 0;

  // 125 MHz clock
  always #4 sys_clk_i = ~sys_clk_i;

  spio_ports uut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(ben),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .pin_in_i(pin_in), .pins_o(pins),
    .periph_out_i(pout), .periph_in_o(pin_f), .analog_sel_o(asel));
  spio_pin_model u_pins (.drive_i(pins), .ext_i(ext), .pin_o(pin_in));

  task give_verdict;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  // One bus access, held until waitrequest is seen low at a rising edge
  task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] b);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    adr <= a;
    wdat <= d;
    ben <= b;
    wr <= w;
    rd <= !w;
    // Waitrequest and read data are taken as they stood at each rising edge
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    `CHK(n < 20, 1'b1)
    if (n >= 20) give_verdict();
  endtask : av

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    av(1'b1, a, d, 4'h1);
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    av(1'b0, a, 32'h0, 4'h0);
    `CHK(q, e)
  endtask : rd_chk

  // Registered pins need one more edge after the access
  task settle;
    repeat (2) @(negedge sys_clk_i);
  endtask : settle

  task t_reset;
    @(negedge sys_clk_i);
    `CHK(pins.oe_n, PINS_RELEASED)
    `CHK(asel, 16'hffff)
    rd_chk(OFS_ANALOG_BASE, 32'hff);
    rd_chk(8'h24, 32'hff);
    rd_chk(OFS_DIR_BASE, 32'h0);
    @(posedge sys_clk_i);
    ext <= 26'h003fc3c;
    rd_chk(8'h08, 32'h0);
    rd_chk(8'h00, 32'h3c);
  endtask : t_reset

  task t_port8;
    wr_reg(8'h00, 32'ha5);
    wr_reg(8'h10, 32'h0f);
    settle();
    `CHK(pins.level[3:0], 4'h5)
    `CHK(pins.oe_n[7:0], 8'hf0)
    rd_chk(8'h00, 32'h35);
    wr_reg(8'h10, 32'hff);
    rd_chk(8'h00, 32'ha5);
    av(1'b1, 8'h00, 32'h11, 4'h0);
    rd_chk(8'h00, 32'ha5);
    wr_reg(8'h40, 32'hff);
    rd_chk(8'h40, 32'h0);
  endtask : t_port8

  task t_analog;
    wr_reg(OFS_ANALOG_BASE, 32'h0);
    wr_reg(8'h24, 32'h0);
    rd_chk(8'h08, 32'hff);
    settle();
    `CHK(asel, 16'h0000)
    @(posedge sys_clk_i);
    ext <= ext | 26'h1000000;
    settle();
    `CHK(pin_f.ext_irq_in[2], 1'b1)
  endtask : t_analog

  task t_periph;
    `CHK(pin_f.ext_irq_in[0], 1'b1)
    @(posedge sys_clk_i);
    pout.time_clock_en <= 1'b1;
    pout.time_clock_output <= 1'b1;
    pout.i2c_sda_en <= 1'b1;
    pout.i2c_sda <= 1'b0;
    settle();
    `CHK(pins.oe_n[PIN_TIME_CLOCK], 1'b0)
    `CHK(pins.level[PIN_TIME_CLOCK], 1'b1)
    `CHK(pins.oe_n[PIN_SDA_SER3_OUT], 1'b0)
    settle();
    `CHK(pin_f.i2c_sda_in, 1'b0)
    @(posedge sys_clk_i);
    pout.i2c_sda <= 1'b1;
    settle();
    settle();
    `CHK(pins.oe_n[PIN_SDA_SER3_OUT], 1'b1)
    `CHK(pin_f.i2c_sda_in, 1'b1)
  endtask : t_periph

  // Serial 3 output alone on port 9, and serial 2 priority over timer 0 on port B
  task t_share;
    @(posedge sys_clk_i);
    pout.i2c_sda_en <= 1'b0;
    pout.serial3_out_en <= 1'b1;
    pout.serial3_out <= 1'b0;
    pout.serial2_out_en <= 1'b1;
    pout.serial2_out <= 1'b0;
    pout.timer0_out_en <= 1'b1;
    pout.timer0_out <= 1'b1;
    settle();
    `CHK(pins.oe_n[PIN_SDA_SER3_OUT], 1'b0)
    `CHK(pins.oe_n[PIN_SER2_OUT_TMR_OUT], 1'b0)
    `CHK(pins.level[PIN_SER2_OUT_TMR_OUT], 1'b0)
    @(posedge sys_clk_i);
    pout.serial2_out_en <= 1'b0;
    settle();
    `CHK(pins.level[PIN_SER2_OUT_TMR_OUT], 1'b1)
  endtask : t_share

  // Reset for ten cycles, then the scenarios
  initial begin
    repeat (10) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_port8();
    t_analog();
    t_periph();
    t_share();
    give_verdict();
  end
endmodule : spio_ports_tb_top
